/* File: rtl/prs_supervisor.sv */
// Power and reset supervisor: glitch filters, reset sequencing and memory self-test.
`timescale 1ns/1ps
`default_nettype none

module prs_supervisor
    import prs_pkg::*;
#(
    parameter int STRETCH_CYC = STRETCH_CYC_DEF
)
(
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       CE,
    input  wire logic       POWER_ON_SENSE,
    input  wire logic       POWER_GOOD_WARN,
    input  wire logic       ADDR_SEL_STRAP,
    input  wire logic       INT_RESET_REQ,
    input  wire logic       SW_RESET_RELEASE,
    input  wire logic       SW_RESET_FORCE,
    input  wire logic       STANDBY_REQ,
    input  wire logic [7:0] TEST_STUCK_MASK,
    output var  logic       EXT_RESET_OUT_N,
    output var  logic       CTRL_RESET,
    output var  logic       PARK_REQ,
    output var  logic       POWER_STATE,
    output var  logic       INIT_DONE,
    output var  logic       MEM_TEST_PASS,
    output var  logic       MEM_TEST_FAIL,
    output var  logic       CODE_XFER_EN,
    output var  logic [7:0] I2C_ADDR_WR,
    output var  logic [7:0] I2C_ADDR_RD
);

    localparam logic [STR_W-1:0] STR_LAST = STR_W'(STRETCH_CYC - 1);

    logic [SYNC_IN_W-1:0] sync_q;
    logic                 sense_s;
    logic                 pg_s;
    logic                 strap_s;
    logic [LOW_W-1:0]     pg_low_cnt;
    logic [HIGH_W-1:0]    pg_high_cnt;
    logic                 pg_fault;
    logic                 pg_active;
    prs_park_t            pk_state;
    logic [PARK_W-1:0]    pk_cnt;
    logic                 ctrl_rst_int;
    prs_rst_t             rs_state;
    prs_rst_t             next_rs;
    logic [DLY_W-1:0]     dly_cnt;
    logic [STR_W-1:0]     str_cnt;
    prs_mt_t              mt_state;
    prs_mt_t              next_mt;
    logic [MEM_AW-1:0]    mt_addr;
    logic [PUL_W-1:0]     mt_cnt;
    logic [MEM_DW-1:0]    mem_rdata;
    logic [MEM_DW-1:0]    pattern;
    logic [1:0]           settle;
    logic                 strap_sel;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    prs_sync u_sync
    (
        .clk  (CLK),
        .srst (SRST),
        .ce   (CE),
        .d    ({ADDR_SEL_STRAP, POWER_GOOD_WARN, POWER_ON_SENSE}),
        .q    (sync_q)
    );

    assign sense_s = sync_q[0];
    assign pg_s    = sync_q[1];
    assign strap_s = sync_q[2];

    // ------------------------------------------------------------------
    // Power-good glitch filter and qualification
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pg_low_cnt  <= '0;
            pg_high_cnt <= '0;
            pg_fault    <= 1'b0;
            pg_active   <= 1'b0;
        end
        else if (CE)
        begin
            if (!pg_s)
            begin
                pg_high_cnt <= '0;
                pg_active   <= 1'b0;
                if (!pg_fault)
                begin
                    pg_fault   <= (pg_low_cnt == LOW_LAST);
                    pg_low_cnt <= pg_low_cnt + 1'b1;
                end
            end
            else
            begin
                pg_low_cnt <= '0;
                if (!pg_active)
                begin
                    if (pg_high_cnt == HIGH_LAST)
                    begin
                        pg_active <= 1'b1;
                        pg_fault  <= 1'b0;
                    end
                    pg_high_cnt <= pg_high_cnt + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Park sequence followed by controller reset
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pk_state <= PK_RUN;
            pk_cnt   <= '0;
        end
        else if (CE)
        begin
            case (pk_state)
                PK_RUN:
                begin
                    pk_cnt <= '0;
                    if (pg_fault)
                    begin
                        pk_state <= PK_PARK;
                    end
                end
                PK_PARK:
                begin
                    pk_cnt <= pk_cnt + 1'b1;
                    if (pk_cnt == PARK_LAST)
                    begin
                        pk_state <= PK_RESET;
                    end
                end
                PK_RESET:
                begin
                    if (pg_active && pg_s)
                    begin
                        pk_state <= PK_RUN;
                    end
                end
                default:
                begin
                    pk_state <= PK_RUN;
                end
            endcase
        end
    end

    assign ctrl_rst_int = (pk_state == PK_RESET) || !sense_s;

    // ------------------------------------------------------------------
    // External reset sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        next_rs = rs_state;
        case (rs_state)
            RS_IDLE:
            begin
                if (pg_fault || INT_RESET_REQ)
                begin
                    next_rs = RS_DELAY;
                end
            end
            RS_DELAY:
            begin
                if (dly_cnt == DLY_LAST)
                begin
                    next_rs = RS_HELD;
                end
            end
            RS_HELD:
            begin
                if (sense_s && !pg_fault && (pk_state == PK_RUN) && SW_RESET_RELEASE)
                begin
                    next_rs = RS_STRETCH;
                end
            end
            RS_STRETCH:
            begin
                if (pg_fault || INT_RESET_REQ)
                begin
                    next_rs = RS_HELD;
                end
                else if (str_cnt == STR_LAST)
                begin
                    next_rs = RS_IDLE;
                end
            end
            default:
            begin
                next_rs = RS_HELD;
            end
        endcase
        if (!sense_s)
        begin
            next_rs = RS_HELD;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            rs_state <= RS_HELD;
            dly_cnt  <= '0;
            str_cnt  <= '0;
        end
        else if (CE)
        begin
            rs_state <= next_rs;
            dly_cnt  <= (rs_state == RS_DELAY) ? dly_cnt + 1'b1 : '0;
            str_cnt  <= (rs_state == RS_STRETCH) ? str_cnt + 1'b1 : '0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            EXT_RESET_OUT_N <= 1'b0;
            CTRL_RESET      <= 1'b1;
            PARK_REQ        <= 1'b0;
            POWER_STATE     <= 1'b0;
        end
        else if (CE)
        begin
            EXT_RESET_OUT_N <= !((next_rs == RS_HELD) || (next_rs == RS_STRETCH)
                                 || SW_RESET_FORCE);
            CTRL_RESET      <= ctrl_rst_int;
            PARK_REQ        <= (pk_state == PK_PARK);
            POWER_STATE     <= !STANDBY_REQ && !ctrl_rst_int
                               && (next_rs == RS_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Memory self-test
    // ------------------------------------------------------------------
    assign pattern = {mt_addr, ~mt_addr};

    prs_mem u_mem
    (
        .clk        (CLK),
        .ce         (CE),
        .we         (mt_state == MT_WRITE),
        .addr       (mt_addr),
        .wdata      (pattern),
        .stuck_mask (TEST_STUCK_MASK),
        .rdata      (mem_rdata)
    );

    always_comb
    begin
        next_mt = mt_state;
        case (mt_state)
            MT_IDLE:     next_mt = MT_WRITE;
            MT_WRITE:    next_mt = (mt_addr == MEM_LAST) ? MT_READ : MT_WRITE;
            MT_READ:     next_mt = MT_CHECK;
            MT_CHECK:
            begin
                if (mem_rdata != pattern)
                begin
                    next_mt = MT_FAIL_P1;
                end
                else
                begin
                    next_mt = (mt_addr == MEM_LAST) ? MT_PASS_P : MT_READ;
                end
            end
            MT_PASS_P:   next_mt = (mt_cnt == PUL_LAST) ? MT_PASS : MT_PASS_P;
            MT_FAIL_P1:  next_mt = (mt_cnt == PUL_LAST) ? MT_FAIL_GAP : MT_FAIL_P1;
            MT_FAIL_GAP: next_mt = (mt_cnt == PUL_LAST) ? MT_FAIL_P2 : MT_FAIL_GAP;
            MT_FAIL_P2:  next_mt = (mt_cnt == PUL_LAST) ? MT_HALT : MT_FAIL_P2;
            MT_PASS:     next_mt = MT_PASS;
            MT_HALT:     next_mt = MT_HALT;
            default:     next_mt = MT_IDLE;
        endcase
    end

    // A controller reset restarts the test from the beginning.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            mt_state <= MT_IDLE;
            mt_addr  <= '0;
            mt_cnt   <= '0;
        end
        else if (CE)
        begin
            if (ctrl_rst_int)
            begin
                mt_state <= MT_IDLE;
                mt_addr  <= '0;
                mt_cnt   <= '0;
            end
            else
            begin
                mt_state <= next_mt;
                mt_cnt   <= (next_mt != mt_state) ? '0 : mt_cnt + 1'b1;
                if ((mt_state == MT_WRITE) || ((mt_state == MT_CHECK) && (next_mt == MT_READ)))
                begin
                    mt_addr <= mt_addr + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            INIT_DONE     <= 1'b0;
            MEM_TEST_PASS <= 1'b0;
            MEM_TEST_FAIL <= 1'b0;
            CODE_XFER_EN  <= 1'b0;
        end
        else if (CE)
        begin
            INIT_DONE     <= !ctrl_rst_int && ((next_mt == MT_PASS_P)
                             || (next_mt == MT_FAIL_P1) || (next_mt == MT_FAIL_P2));
            MEM_TEST_PASS <= !ctrl_rst_int && (next_mt == MT_PASS);
            MEM_TEST_FAIL <= !ctrl_rst_int && (next_mt == MT_HALT);
            CODE_XFER_EN  <= !ctrl_rst_int && (next_mt == MT_PASS);
        end
    end

    // ------------------------------------------------------------------
    // Address strap capture
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            settle      <= '0;
            strap_sel   <= 1'b0;
            I2C_ADDR_WR <= ADDR_DEF_WR;
            I2C_ADDR_RD <= ADDR_DEF_RD;
        end
        else if (CE)
        begin
            if (settle != SETTLE_LAST)
            begin
                settle <= settle + 1'b1;
            end
            if (!sense_s || (settle != SETTLE_LAST))
            begin
                strap_sel <= strap_s;
            end
            I2C_ADDR_WR <= strap_sel ? ADDR_ALT_WR : ADDR_DEF_WR;
            I2C_ADDR_RD <= strap_sel ? ADDR_ALT_RD : ADDR_DEF_RD;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK iff CE);
    endclocking
    default disable iff (SRST);

    a_por_hold: assert property (!sense_s |=> !EXT_RESET_OUT_N)
        else $error("Reset output high while sense is low.");
    a_sw_hold: assert property ((rs_state == RS_HELD) && !SW_RESET_RELEASE |=>
        !EXT_RESET_OUT_N) else $error("Reset released without software.");
    a_fault_delay: assert property ($rose(rs_state == RS_HELD) && $past(sense_s)
        && ($past(rs_state) == RS_DELAY) |-> $past(dly_cnt) == DLY_LAST)
        else $error("Fault delay length wrong.");
    a_stretch_len: assert property ($rose(rs_state == RS_IDLE)
        && ($past(rs_state) == RS_STRETCH) |-> $past(str_cnt) == STR_LAST)
        else $error("Reset stretch too short.");
    a_sw_force: assert property (SW_RESET_FORCE |=> !EXT_RESET_OUT_N)
        else $error("Forced reset not driven.");
    a_glitch_fault: assert property ($rose(pg_fault) |->
        !$past(pg_s) && ($past(pg_low_cnt) == LOW_LAST))
        else $error("Power-good fault without full low time.");
    a_park_reset: assert property ((pk_state == PK_PARK) && (pk_cnt == PARK_LAST)
        |=> (pk_state == PK_RESET) ##1 CTRL_RESET) else $error("Park not followed by reset.");
    a_hold_low_pg: assert property ((pk_state == PK_RESET) && !pg_s |=>
        (pk_state == PK_RESET)) else $error("Left reset while power-good low.");
    a_pg_qualify: assert property ($rose(pg_active) |->
        $past(pg_s) && ($past(pg_high_cnt) == HIGH_LAST))
        else $error("Power-good qualified too early.");
    a_power_state: assert property (POWER_STATE |-> !CTRL_RESET)
        else $error("Power state high during reset.");
    a_halt_no_xfer: assert property ((mt_state == MT_HALT) && !ctrl_rst_int |=>
        MEM_TEST_FAIL && !CODE_XFER_EN) else $error("Code transfer after failed test.");
    a_fail_two_pulse: assert property (disable iff (SRST || ctrl_rst_int)
        $fell(INIT_DONE) && (mt_state == MT_FAIL_GAP) |-> ##16 INIT_DONE)
        else $error("Second init-done pulse missing.");
    a_strap_addr: assert property (strap_sel |=> (I2C_ADDR_WR == ADDR_ALT_WR))
        else $error("Strap address pair wrong.");

    c_park_seen:   cover property ((pk_state == PK_PARK) ##1 (pk_state == PK_PARK));
    c_stretch_end: cover property ((rs_state == RS_STRETCH) ##1 (rs_state == RS_IDLE));
    c_test_pass:   cover property ($rose(CODE_XFER_EN));
    c_test_fail:   cover property ($rose(MEM_TEST_FAIL));

endmodule // prs_supervisor

`default_nettype wire

/* File: include/prs_pkg.sv */
// Constants, types and timing figures shared by the power and reset supervisor.
//
// Overview of operation
// - Sense low drives reset output low immediately
// - Reset stays low until software releases it
// - Fault or internal reset asserts output after 5 us
// - Output held 2 ms after software release
// - Software control forces reset output directly
// - Power-good low 4 us parks, then resets
// - Held in reset while power-good stays low
// - Power-good active after 625 ns high
// - Power-state high when powered, low in standby
// - Memory initialised and tested before code transfer
// - Memory test failure halts initialisation
// - Failure shown by two init-done pulses
// - Strap picks I2C address pair at power-up
`default_nettype none

package prs_pkg;

    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 5;
    localparam int RST_DELAY_NS    = 5000;
    localparam int PG_LOW_MIN_NS   = 4000;
    localparam int PG_HIGH_MIN_NS  = 625;
    localparam int STRETCH_MIN_MS  = 2;
    localparam int NS_PER_MS       = 1000000;

    // Approximate delay rounds down, minimum times round up.
    localparam int RST_DELAY_CYC   = RST_DELAY_NS / CLK_PERIOD_NS;
    localparam int PG_LOW_CYC      = (PG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PG_HIGH_CYC     = (PG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_CYC_DEF =
        (STRETCH_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Counter widths and terminal counts
    // ------------------------------------------------------------------
    localparam int DLY_W  = 10;
    localparam int LOW_W  = 10;
    localparam int HIGH_W = 7;
    localparam int STR_W  = 20;
    localparam int PARK_W = 6;
    localparam int PUL_W  = 4;

    localparam logic [DLY_W-1:0]  DLY_LAST  = DLY_W'(RST_DELAY_CYC - 1);
    localparam logic [LOW_W-1:0]  LOW_LAST  = LOW_W'(PG_LOW_CYC - 1);
    localparam logic [HIGH_W-1:0] HIGH_LAST = HIGH_W'(PG_HIGH_CYC - 1);
    localparam logic [PARK_W-1:0] PARK_LAST = 6'h3f;
    localparam logic [PUL_W-1:0]  PUL_LAST  = 4'hf;

    // ------------------------------------------------------------------
    // Test memory and synchroniser
    // ------------------------------------------------------------------
    localparam int MEM_AW = 4;
    localparam int MEM_DW = 8;
    localparam logic [MEM_AW-1:0] MEM_LAST = 4'hf;
    localparam int SYNC_IN_W = 3;
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // ------------------------------------------------------------------
    // Host I2C address pairs (write, read)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DEF_WR = 8'h34;
    localparam logic [7:0] ADDR_DEF_RD = 8'h35;
    localparam logic [7:0] ADDR_ALT_WR = 8'h3a;
    localparam logic [7:0] ADDR_ALT_RD = 8'h3b;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {RS_IDLE, RS_DELAY, RS_HELD, RS_STRETCH} prs_rst_t;
    typedef enum logic [1:0] {PK_RUN, PK_PARK, PK_RESET} prs_park_t;
    typedef enum logic [3:0] {
        MT_IDLE, MT_WRITE, MT_READ, MT_CHECK, MT_PASS_P, MT_PASS,
        MT_FAIL_P1, MT_FAIL_GAP, MT_FAIL_P2, MT_HALT
    } prs_mt_t;

endpackage

`default_nettype wire

/* File: rtl/prs_sync.sv */
// Two-stage synchroniser for asynchronous supervisor pins.
`timescale 1ns/1ps
`default_nettype none

module prs_sync
    import prs_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 ce,
    input  wire logic [SYNC_IN_W-1:0] d,
    output var  logic [SYNC_IN_W-1:0] q
);

    logic [SYNC_IN_W-1:0] meta;

    // Each pin has its own pair of flip-flops; only the second is read outside.
    for (genvar i = 0; i < SYNC_IN_W; i++)
    begin : g_bit
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                meta[i] <= 1'b0;
                q[i]    <= 1'b0;
            end
            else if (ce)
            begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    end

endmodule // prs_sync

`default_nettype wire

/* File: rtl/prs_mem.sv */
// Small internal memory exercised by the power-up self-test.
`timescale 1ns/1ps
`default_nettype none

module prs_mem
    import prs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              ce,
    input  wire logic              we,
    input  wire logic [MEM_AW-1:0] addr,
    input  wire logic [MEM_DW-1:0] wdata,
    input  wire logic [MEM_DW-1:0] stuck_mask,
    output var  logic [MEM_DW-1:0] rdata
);

    logic [MEM_DW-1:0] mem [0:(1 << MEM_AW) - 1];

    // The stuck mask models defective cells that read back as one.
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr] | stuck_mask;
        end
    end

endmodule // prs_mem

`default_nettype wire

/* File: sim/prs_monitor_model.sv */
// Behavioural supply monitor that drives the sense and power-good pins.
`timescale 1ns/1ps
`default_nettype none

module prs_monitor_model #(
    parameter int WARN_CYC = 100
)
(
    input  wire logic clk,
    input  wire logic supply_ok,
    input  wire logic glitch,
    output var  logic sense,
    output var  logic good
);
    int unsigned hold = 0;

    initial
    begin
        sense = 1'b0;
        good  = 1'b0;
    end

    // Power-good warns first; sense follows only after the warning interval.
    always @(posedge clk)
    begin
        good <= supply_ok & ~glitch;
        if (supply_ok)
        begin
            sense <= 1'b1;
            hold  <= 0;
        end
        else if (hold < WARN_CYC)
            hold <= hold + 1;
        else
            sense <= 1'b0;
    end
endmodule // prs_monitor_model

`default_nettype wire

/* File: sim/power_reset_supervisor_test.sv */
// Self-checking bench for the power and reset supervisor.
`timescale 1ns/1ps
`default_nettype none

module power_reset_supervisor_test;
    localparam int STR = 200;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       supply_ok = 1'b0;
    logic       glitch = 1'b0;
    logic       strap = 1'b0;
    logic       rel = 1'b0;
    logic       frc = 1'b0;
    logic       stby = 1'b0;
    logic       irq = 1'b0;
    logic       done_q = 1'b0;
    logic [7:0] mask = 8'hff;
    logic       sense, good, ext_n, ctrl, park, pstate, done, pass, fail, xfer;
    logic [7:0] awr, ard;
    int         mismatches = 0;
    int         checks = 0;
    int         cyc = 0;
    int         park_cnt = 0;
    int         n;

    always #2.5 clk = ~clk;
    always @(negedge clk) if (park === 1'b1) park_cnt++;

    prs_supervisor #(.STRETCH_CYC(STR)) dut (.CLK(clk), .SRST(srst), .CE(1'b1),
        .POWER_ON_SENSE(sense), .POWER_GOOD_WARN(good), .ADDR_SEL_STRAP(strap),
        .INT_RESET_REQ(irq), .SW_RESET_RELEASE(rel), .SW_RESET_FORCE(frc),
        .STANDBY_REQ(stby), .TEST_STUCK_MASK(mask), .EXT_RESET_OUT_N(ext_n),
        .CTRL_RESET(ctrl), .PARK_REQ(park), .POWER_STATE(pstate), .INIT_DONE(done),
        .MEM_TEST_PASS(pass), .MEM_TEST_FAIL(fail), .CODE_XFER_EN(xfer),
        .I2C_ADDR_WR(awr), .I2C_ADDR_RD(ard));
    prs_monitor_model mon (.clk(clk), .supply_ok(supply_ok), .glitch(glitch),
        .sense(sense), .good(good));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_strap;
        strap <= 1'b1;
        tick(6);
        @(negedge clk);
        chk("addr_wr", 8'h3a, awr);
        chk("addr_rd", 8'h3b, ard);
        chk("ext_n", 8'h00, {7'h0, ext_n});
        tick(1);
        strap <= 1'b0;
        tick(6);
        @(negedge clk);
        chk("addr_wr", 8'h34, awr);
        chk("addr_rd", 8'h35, ard);
    endtask

    task automatic t_memtest(input logic [7:0] m, input int rises, input logic ok);
        tick(1);
        mask <= m;
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        n = 0;
        done_q = 1'b0;
        repeat (400)
        begin
            @(negedge clk);
            if (done === 1'b1 && done_q !== 1'b1) n++;
            done_q = done;
        end
        chk("init_pulses", rises[7:0], n[7:0]);
        chk("pass", {7'h0, ok}, {7'h0, pass});
        chk("fail", {7'h0, ~ok}, {7'h0, fail});
        chk("xfer", {7'h0, ok}, {7'h0, xfer});
    endtask

    task automatic t_release(input int gap);
        tick(1);
        rel <= 1'b1;
        tick(1);
        rel <= 1'b0;
        tick(gap);
    endtask

    task automatic t_int_reset;
        tick(1);
        irq <= 1'b1;
        tick(1);
        irq <= 1'b0;
        tick(990);
        @(negedge clk);
        chk("ext_n", 8'h01, {7'h0, ext_n});
        tick(15);
        @(negedge clk);
        chk("ext_n", 8'h00, {7'h0, ext_n});
        t_release(STR + 10);
        @(negedge clk);
        chk("ext_n", 8'h01, {7'h0, ext_n});
    endtask

    initial
    begin
        tick(2);
        srst <= 1'b0;
        t_strap();
        tick(1);
        supply_ok <= 1'b1;
        t_memtest(8'hff, 2, 1'b0);
        t_memtest(8'h00, 1, 1'b1);
        @(negedge clk);
        chk("ext_n", 8'h00, {7'h0, ext_n});
        t_release(STR - 10);
        @(negedge clk);
        chk("ext_n", 8'h00, {7'h0, ext_n});
        tick(15);
        @(negedge clk);
        chk("ext_n", 8'h01, {7'h0, ext_n});
        chk("pstate", 8'h01, {7'h0, pstate});
        tick(1);
        stby <= 1'b1;
        frc <= 1'b1;
        tick(3);
        @(negedge clk);
        chk("pstate", 8'h00, {7'h0, pstate});
        chk("ext_n", 8'h00, {7'h0, ext_n});
        tick(1);
        stby <= 1'b0;
        frc <= 1'b0;
        tick(3);
        @(negedge clk);
        chk("ext_n", 8'h01, {7'h0, ext_n});
        t_int_reset();
        park_cnt = 0;
        tick(1);
        glitch <= 1'b1;
        tick(700);
        glitch <= 1'b0;
        tick(10);
        glitch <= 1'b1;
        tick(700);
        glitch <= 1'b0;
        tick(100);
        @(negedge clk);
        chk("park_cycles", 8'h00, park_cnt[7:0]);
        chk("ext_n", 8'h01, {7'h0, ext_n});
        tick(1);
        glitch <= 1'b1;
        tick(1500);
        @(negedge clk);
        chk("ext_n", 8'h01, {7'h0, ext_n});
        tick(500);
        @(negedge clk);
        chk("park_cycles", 8'd64, park_cnt[7:0]);
        chk("ctrl", 8'h01, {7'h0, ctrl});
        chk("ext_n", 8'h00, {7'h0, ext_n});
        tick(1);
        glitch <= 1'b0;
        tick(100);
        @(negedge clk);
        chk("ctrl", 8'h01, {7'h0, ctrl});
        tick(40);
        @(negedge clk);
        chk("ctrl", 8'h00, {7'h0, ctrl});
        t_release(STR + 10);
        @(negedge clk);
        chk("ext_n", 8'h01, {7'h0, ext_n});
        tick(1);
        supply_ok <= 1'b0;
        n = 0;
        while (sense !== 1'b0 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        tick(3);
        @(negedge clk);
        chk("ext_n", 8'h00, {7'h0, ext_n});
        give_verdict();
    end
endmodule // power_reset_supervisor_test

`default_nettype wire
